// >>> verilog/compact_word_store_pkg.sv
package compact_word_store_pkg;

  localparam int WORD_W = 32;
  localparam int IDX_W = 5;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = 64;

  localparam logic [4:0] ZERO_REG = 5'h00;
  localparam logic [4:0] LIST_BASE_REG = 5'h10;
  localparam logic [4:0] SHORT_ALT_REG = 5'h11;
  localparam logic [4:0] STACK_REG = 5'h1D;
  localparam logic [4:0] FRAME_REG = 5'h1E;
  localparam logic [4:0] LINK_REG = 5'h1F;

  localparam logic [3:0] WIDE_LOW_MAX = 4'h9;
  localparam logic [3:0] WIDE_FRAME_STEP = 4'h8;
  localparam logic [3:0] SHORT_LIST_MIN = 4'h2;
  localparam logic [3:0] PAIR_COUNT = 4'h2;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [1:0] ALIGN_OK = 2'h0;

  localparam logic [2:0] EXC_NONE = 3'h0;
  localparam logic [2:0] EXC_ADDR = 3'h1;
  localparam logic [2:0] EXC_REFILL = 3'h2;
  localparam logic [2:0] EXC_INVALID = 3'h3;
  localparam logic [2:0] EXC_MODIFIED = 3'h4;
  localparam logic [2:0] EXC_WATCH = 3'h5;

  typedef enum logic [2:0] {
    short_modulo_subtract = 3'h0,
    short_exclusive_or = 3'h1,
    short_word_store = 3'h2,
    stack_word_store = 3'h3,
    wide_multi_word_store = 3'h4,
    short_multi_word_store = 3'h5,
    paired_word_store = 3'h6
  } op_kind_e;

  function automatic logic [4:0] map_short_reg(input logic [2:0] sel);
    map_short_reg = (sel == 3'h0) ? LIST_BASE_REG :
                    (sel == 3'h1) ? SHORT_ALT_REG : {2'h0, sel};
  endfunction

  function automatic logic [4:0] map_short_data(input logic [2:0] sel);
    map_short_data = (sel == 3'h0) ? ZERO_REG :
                     (sel == 3'h1) ? SHORT_ALT_REG : {2'h0, sel};
  endfunction

endpackage

// >>> verilog/list_if.sv
interface list_if;
  import compact_word_store_pkg::*;
  op_kind_e kind;
  logic [4:0] list_field;
  logic [4:0] data_reg;
  logic [3:0] step;
  logic [4:0] reg_num;
  logic [3:0] count;
  modport requester (output kind, list_field, data_reg, step,
                     input reg_num, count);
  modport decoder (input kind, list_field, data_reg, step,
                   output reg_num, count);
endinterface

// >>> verilog/list_decoder.sv
module list_decoder
  import compact_word_store_pkg::*;
(
  // Decode request and answer.
  list_if.decoder lif
);

  logic [3:0] low;

  always_comb
  begin
    low = 4'h0;
    lif.reg_num = lif.data_reg;
    lif.count = 4'h1;
    case (lif.kind)
      // RQ10: wide list decode
      wide_multi_word_store:
      begin
        low = (lif.list_field[3:0] <= WIDE_LOW_MAX) ?
              lif.list_field[3:0] : 4'h0;
        lif.count = low + {3'h0, lif.list_field[4]};
        if (lif.step < low)
          lif.reg_num = (lif.step == WIDE_FRAME_STEP) ? FRAME_REG :
                        LIST_BASE_REG + {1'b0, lif.step};
        else
          lif.reg_num = LINK_REG;
      end
      // RQ12: short list decode
      short_multi_word_store:
      begin
        lif.count = SHORT_LIST_MIN + {2'h0, lif.list_field[1:0]};
        lif.reg_num = (lif.step <= {2'h0, lif.list_field[1:0]}) ?
                      LIST_BASE_REG + {1'b0, lif.step} : LINK_REG;
      end
      // RQ14: pair uses next register
      paired_word_store:
      begin
        lif.count = PAIR_COUNT;
        lif.reg_num = lif.data_reg + {4'h0, lif.step[0]};
      end
      default:
      begin
        lif.count = 4'h1;
        lif.reg_num = lif.data_reg;
      end
    endcase
  end

endmodule

// >>> verilog/word_fifo.sv
module word_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  // Clock and control.
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic flush,
  // Fill side.
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side.
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  // Status.
  output logic idle
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = cnt_reg != FULL_CNT;
  assign push = in_valid && in_ready;
  assign pop = (cnt_reg != '0) && (!out_valid || out_ready);
  assign idle = (cnt_reg == '0) && !out_valid;

  // Storage carries no reset; pointers, count and the output register define state.
  always_ff @(posedge clock)
  begin
    if (clk_en && push && !flush)
      mem_reg[wr_reg] <= in_data;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (clk_en)
    begin
      if (flush)
      begin
        wr_reg <= '0;
        rd_reg <= '0;
        cnt_reg <= '0;
        out_valid <= 1'b0;
      end
      else
      begin
        if (push)
          wr_reg <= wr_reg + 1'b1;
        if (pop)
        begin
          rd_reg <= rd_reg + 1'b1;
          out_data <= mem_reg[rd_reg];
        end
        cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        out_valid <= pop || (out_valid && !out_ready);
      end
    end
  end

endmodule

// >>> verilog/compact_word_store_unit.sv
// Notes on behaviour
// RQ1: Subtract wraps modulo two to thirty-two, no trap.
// RQ2: Short ALU selectors reach registers 2-7, 16, 17.
// RQ3: Exclusive OR result replaces second operand register.
// RQ4: Short store adds offset times four to base.
// RQ5: Short store base and data selectors remapped.
// RQ6: Single stores write full data word.
// RQ7: Stack store uses register 29 plus offset.
// RQ8: Any misaligned word store raises address error.
// RQ9: Wide multi store sign-extends twelve-bit offset.
// RQ10: Wide list decodes counts, 30 and 31.
// RQ11: List order stored, address steps by four.
// RQ12: Short list stores 16 upward, then 31.
// RQ13: Short multi uses stack pointer plus offset.
// RQ14: Pair stores first then next register.
// RQ15: Software never pairs starting at register 31.
// RQ16: Software keeps multi stores out of delay slots.
// RQ17: Interrupts always held off during multi-word stores.
// RQ18: Each word translated separately, faults reported.
// RQ19: Misaligned start stores no word at all.
// RQ20: Fault reports its address, later words dropped.
module compact_word_store_unit
  import compact_word_store_pkg::*;
(
  // Clock, reset, enable.
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  // Operation request.
  input wire logic op_valid,
  input wire op_kind_e op_kind,
  input wire logic [4:0] op_rs,
  input wire logic [4:0] op_rt,
  input wire logic [2:0] op_rd,
  input wire logic [11:0] op_offset,
  input wire logic [4:0] op_list,
  output logic op_ready,
  output logic op_done,
  // Register file read port.
  output logic [4:0] reg_rd_idx,
  input wire logic [31:0] reg_rd_data,
  // Register write-back.
  output logic wb_valid,
  output logic [4:0] wb_idx,
  output logic [31:0] wb_data,
  // Store path with translation.
  output logic st_valid,
  output logic [31:0] st_addr,
  output logic [31:0] st_data,
  input wire logic st_ready,
  input wire logic st_fault,
  input wire logic [2:0] st_fault_code,
  // Exceptions and interrupt hold.
  output logic exc_valid,
  output logic [2:0] exc_code,
  output logic [31:0] exc_addr,
  output logic irq_hold
);

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_BASE = 3'h1,
    S_ALU = 3'h2,
    S_DATA = 3'h3,
    S_DRAIN = 3'h4
  } state_e;

  state_e state_reg;
  op_kind_e kind_reg;
  logic [4:0] data_idx_reg;
  logic [4:0] opb_idx_reg;
  logic [4:0] dest_reg;
  logic [4:0] list_reg;
  logic [31:0] off_reg;
  logic [31:0] opa_reg;
  logic [31:0] addr_reg;
  logic [3:0] step_reg;
  logic [31:0] last_push_addr_reg;

  logic [4:0] acc_base;
  logic [4:0] acc_data;
  logic [4:0] acc_opb;
  logic [4:0] acc_dest;
  logic [31:0] acc_off;
  logic [31:0] ea;
  logic is_alu;
  logic is_multi;
  logic misaligned;
  logic last;
  logic push;
  logic fault_hit;
  logic fifo_ready;
  logic fifo_idle;
  logic [63:0] fifo_out;

  list_if lif ();

  list_decoder u_list (
    .lif(lif)
  );

  // RQ6: full data word
  word_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .flush(fault_hit),
    .in_valid(push),
    .in_data({addr_reg, reg_rd_data}),
    .in_ready(fifo_ready),
    .out_valid(st_valid),
    .out_data(fifo_out),
    .out_ready(st_ready),
    .idle(fifo_idle)
  );

  assign st_addr = fifo_out[63:32];
  assign st_data = fifo_out[31:0];

  assign lif.kind = kind_reg;
  assign lif.list_field = list_reg;
  assign lif.data_reg = data_idx_reg;
  assign lif.step = (state_reg == S_DATA) ? step_reg + 4'h1 : 4'h0;

  assign is_alu = (kind_reg == short_modulo_subtract) ||
                  (kind_reg == short_exclusive_or);
  assign is_multi = (kind_reg == wide_multi_word_store) ||
                    (kind_reg == short_multi_word_store) ||
                    (kind_reg == paired_word_store);
  assign ea = reg_rd_data + off_reg;
  // RQ8: low address bits
  assign misaligned = ea[1:0] != ALIGN_OK;
  assign last = (step_reg + 4'h1) == lif.count;
  // RQ18: per-word fault sample
  assign fault_hit = st_valid && st_ready && st_fault;
  // RQ20: no push once faulted
  assign push = (state_reg == S_DATA) && fifo_ready && !fault_hit;

  always_comb
  begin
    acc_base = op_rs;
    acc_data = op_rt;
    acc_opb = map_short_reg(op_rt[2:0]);
    acc_dest = map_short_reg(op_rd);
    acc_off = {{20{op_offset[11]}}, op_offset};
    case (op_kind)
      // RQ2: ALU selector map
      short_modulo_subtract:
        acc_base = map_short_reg(op_rs[2:0]);
      // RQ3: result to second operand
      short_exclusive_or:
      begin
        acc_base = map_short_reg(op_rs[2:0]);
        acc_dest = map_short_reg(op_rt[2:0]);
      end
      // RQ5: short store selector maps
      short_word_store:
      begin
        acc_base = map_short_reg(op_rs[2:0]);
        acc_data = map_short_data(op_rt[2:0]);
        // RQ4: offset scaled by four
        acc_off = {26'h0, op_offset[3:0], 2'h0};
      end
      // RQ7: stack base and offset
      stack_word_store:
      begin
        acc_base = STACK_REG;
        acc_off = {25'h0, op_offset[4:0], 2'h0};
      end
      // RQ13: stack plus short offset
      short_multi_word_store:
      begin
        acc_base = STACK_REG;
        acc_off = {26'h0, op_offset[3:0], 2'h0};
      end
      // RQ9: signed twelve-bit offset
      wide_multi_word_store:
        acc_off = {{20{op_offset[11]}}, op_offset};
      default:
        acc_off = {{20{op_offset[11]}}, op_offset};
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= S_IDLE;
      op_ready <= 1'b1;
      kind_reg <= short_modulo_subtract;
      data_idx_reg <= 5'h00;
      opb_idx_reg <= 5'h00;
      dest_reg <= 5'h00;
      list_reg <= 5'h00;
      off_reg <= 32'h0000_0000;
      opa_reg <= 32'h0000_0000;
      addr_reg <= 32'h0000_0000;
      step_reg <= 4'h0;
      reg_rd_idx <= 5'h00;
    end
    else if (clk_en)
    begin
      case (state_reg)
        S_IDLE:
          if (op_valid)
          begin
            kind_reg <= op_kind;
            data_idx_reg <= acc_data;
            opb_idx_reg <= acc_opb;
            dest_reg <= acc_dest;
            list_reg <= op_list;
            off_reg <= acc_off;
            step_reg <= 4'h0;
            reg_rd_idx <= acc_base;
            op_ready <= 1'b0;
            state_reg <= S_BASE;
          end
        S_BASE:
        begin
          opa_reg <= reg_rd_data;
          if (is_alu)
          begin
            reg_rd_idx <= opb_idx_reg;
            state_reg <= S_ALU;
          end
          // RQ19: check before any word
          else if (misaligned || lif.count == 4'h0)
          begin
            op_ready <= 1'b1;
            state_reg <= S_IDLE;
          end
          else
          begin
            addr_reg <= ea;
            reg_rd_idx <= lif.reg_num;
            state_reg <= S_DATA;
          end
        end
        S_ALU:
        begin
          op_ready <= 1'b1;
          state_reg <= S_IDLE;
        end
        S_DATA:
          if (fault_hit)
          begin
            op_ready <= 1'b1;
            state_reg <= S_IDLE;
          end
          else if (push)
          begin
            if (last)
              state_reg <= S_DRAIN;
            else
            begin
              // RQ11: next word four higher
              step_reg <= step_reg + 4'h1;
              addr_reg <= addr_reg + WORD_STEP;
              reg_rd_idx <= lif.reg_num;
            end
          end
        S_DRAIN:
          if (fault_hit || fifo_idle)
          begin
            op_ready <= 1'b1;
            state_reg <= S_IDLE;
          end
        default:
        begin
          op_ready <= 1'b1;
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wb_valid <= 1'b0;
      wb_idx <= 5'h00;
      wb_data <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      wb_valid <= state_reg == S_ALU;
      wb_idx <= dest_reg;
      // RQ1: modulo subtract, no trap
      if (kind_reg == short_modulo_subtract)
        wb_data <= opa_reg - reg_rd_data;
      else
        wb_data <= opa_reg ^ reg_rd_data;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      exc_valid <= 1'b0;
      exc_code <= EXC_NONE;
      exc_addr <= 32'h0000_0000;
      op_done <= 1'b0;
      irq_hold <= 1'b0;
      last_push_addr_reg <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      exc_valid <= 1'b0;
      // RQ8: address error report
      if (state_reg == S_BASE && !is_alu && misaligned)
      begin
        exc_valid <= 1'b1;
        exc_code <= EXC_ADDR;
        exc_addr <= ea;
      end
      // RQ20: report faulting word
      else if (fault_hit)
      begin
        exc_valid <= 1'b1;
        exc_code <= st_fault_code;
        exc_addr <= st_addr;
      end
      op_done <= (state_reg == S_ALU) ||
                 (state_reg == S_DRAIN && fifo_idle && !fault_hit) ||
                 (state_reg == S_BASE && !is_alu && !misaligned &&
                  lif.count == 4'h0);
      // RQ17: hold interrupts while multi
      irq_hold <= is_multi && (state_reg == S_BASE ||
                  state_reg == S_DATA ||
                  (state_reg == S_DRAIN && !(fifo_idle || fault_hit)));
      if (push)
        last_push_addr_reg <= addr_reg;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_sub_result: assert property ( // RQ1
    clk_en && state_reg == S_ALU && kind_reg == short_modulo_subtract
    |=> wb_valid && wb_data == $past(opa_reg) - $past(reg_rd_data))
    else $error("subtract result wrong");

  chk_xor_result: assert property ( // RQ3
    clk_en && state_reg == S_ALU && kind_reg == short_exclusive_or
    |=> wb_valid && wb_data == ($past(opa_reg) ^ $past(reg_rd_data)))
    else $error("exclusive or result wrong");

  chk_alu_dest_map: assert property ( // RQ2
    wb_valid |-> (wb_idx inside {[5'h02:5'h07], 5'h10, 5'h11}))
    else $error("write-back register outside short set");

  chk_stack_base: assert property ( // RQ7
    clk_en && state_reg == S_IDLE && op_valid &&
    op_kind == stack_word_store |=> reg_rd_idx == 5'h1D)
    else $error("stack store did not read register 29");

  chk_short_addr: assert property ( // RQ4
    clk_en && state_reg == S_BASE && kind_reg == short_word_store &&
    !misaligned |=> addr_reg == $past(reg_rd_data) +
    {26'h0, $past(off_reg[5:2]), 2'h0})
    else $error("short store address wrong");

  chk_align_err: assert property ( // RQ8
    clk_en && state_reg == S_BASE && !is_alu && misaligned
    |=> exc_valid && exc_code == 3'h1 && state_reg == S_IDLE)
    else $error("misaligned store not reported");

  chk_no_misaligned: assert property ( // RQ19
    clk_en && state_reg == S_BASE && !is_alu && misaligned
    |=> (!push && !st_valid) [*2])
    else $error("misaligned start stored a word");

  chk_addr_step: assert property ( // RQ11
    push && step_reg != 4'h0 |-> addr_reg == last_push_addr_reg + 32'h4)
    else $error("store address did not step by four");

  chk_wide_tail: assert property ( // RQ10
    kind_reg == wide_multi_word_store && list_reg == 5'h19
    |-> lif.count == 4'hA &&
    (lif.step != 4'h8 || lif.reg_num == 5'h1E) &&
    (lif.step != 4'h9 || lif.reg_num == 5'h1F))
    else $error("wide list decode wrong");

  chk_short_list: assert property ( // RQ12
    kind_reg == short_multi_word_store && lif.step == lif.count - 4'h1
    |-> lif.reg_num == 5'h1F)
    else $error("short list does not end with 31");

  chk_fault_flush: assert property ( // RQ20
    clk_en && fault_hit |=> exc_valid && exc_addr == $past(st_addr) &&
    !st_valid && state_reg == S_IDLE)
    else $error("fault not reported or not flushed");

  chk_irq_hold: assert property ( // RQ17
    clk_en && is_multi && state_reg == S_DATA |=> irq_hold)
    else $error("interrupts not held during multi store");

  cov_wide_done: cover property (
    kind_reg == wide_multi_word_store && op_done);
  cov_fault_mid: cover property (
    fault_hit && is_multi && step_reg != 4'h0);
  cov_misaligned: cover property (exc_valid && exc_code == EXC_ADDR);
  cov_fifo_full: cover property (state_reg == S_DATA && !fifo_ready);

endmodule

// >>> testbench/store_path_model.sv
module store_path_model (
  // Clock, clear and behaviour.
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic [7:0] fault_at,
  input wire logic [2:0] fault_code,
  // Store path.
  input wire logic st_valid,
  input wire logic [31:0] st_addr,
  input wire logic [31:0] st_data,
  output logic st_ready,
  output logic st_fault,
  output logic [2:0] st_fault_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] q_addr[$];
  logic [31:0] q_data[$];
  logic [7:0] n_seen = 8'h00;
  logic [3:0] cyc = 4'h0;
  logic ready_reg = 1'b0;

  assign st_ready = ready_reg;
  // per-word fault.
  // Each handshake is translated alone, so a fault hits exactly one word.
  assign st_fault = st_valid && (n_seen == fault_at);
  assign st_fault_code = st_fault ? fault_code : 3'h7;

  always @(posedge clock)
  begin
    cyc <= cyc + 4'h1;
    ready_reg <= (mode == 2'h0) || (mode == 2'h1 && cyc[0]) ||
                 (cyc[1:0] == 2'h3);
    if (rst)
    begin
      n_seen <= 8'h00;
      q_addr.delete();
      q_data.delete();
    end
    else if (st_valid && st_ready)
    begin
      n_seen <= n_seen + 8'h01;
      if (!st_fault)
      begin
        q_addr.push_back(st_addr);
        q_data.push_back(st_data);
      end
    end
  end
endmodule

// >>> testbench/compact_word_store_unit_tb.sv
module compact_word_store_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import compact_word_store_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  op_kind_e op_kind = short_modulo_subtract;
  logic [4:0] op_rs = 5'h00;
  logic [4:0] op_rt = 5'h00;
  logic [2:0] op_rd = 3'h0;
  logic [11:0] op_offset = 12'h000;
  logic [4:0] op_list = 5'h00;
  logic op_ready, op_done, wb_valid, st_valid, st_ready, st_fault;
  logic exc_valid, irq_hold;
  logic [4:0] reg_rd_idx, wb_idx, wb_i;
  logic [31:0] reg_rd_data, wb_data, st_addr, st_data, exc_addr, wb_d;
  logic [2:0] st_fault_code, exc_code;
  logic pclr = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [7:0] fault_at = 8'hFF;
  logic [2:0] fault_code = 3'h0;
  logic [31:0] regs [32];
  logic [31:0] exp_a[$];
  logic [31:0] exp_d[$];
  logic got_done, got_exc, got_wb, got_hold;
  int n_errors = 0;
  int n_compared = 0;

  always #20 clock = ~clock;
  assign reg_rd_data = regs[reg_rd_idx];

  compact_word_store_unit dut (
    .clock, .rst, .clk_en(1'b1), .op_valid, .op_kind, .op_rs, .op_rt,
    .op_rd, .op_offset, .op_list, .op_ready, .op_done, .reg_rd_idx,
    .reg_rd_data, .wb_valid, .wb_idx, .wb_data, .st_valid, .st_addr,
    .st_data, .st_ready, .st_fault, .st_fault_code, .exc_valid,
    .exc_code, .exc_addr, .irq_hold
  );

  store_path_model pm (
    .clock, .rst(pclr), .mode, .fault_at, .fault_code, .st_valid,
    .st_addr, .st_data, .st_ready, .st_fault, .st_fault_code
  );

  function automatic logic [4:0] alu_reg(logic [2:0] s);
    return (s == 3'h0) ? 5'h10 : (s == 3'h1) ? 5'h11 : {2'h0, s};
  endfunction

  function automatic logic [4:0] dat_reg(logic [2:0] s);
    return (s == 3'h0) ? 5'h00 : (s == 3'h1) ? 5'h11 : {2'h0, s};
  endfunction

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp_val(logic [31:0] got, logic [31:0] exp, string what);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask

  task automatic cmp_flag(logic got, logic exp, string what);
    cmp_val({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic prep(logic [1:0] m, logic [7:0] fa, logic [2:0] fc);
    @(posedge clock);
    pclr <= 1'b1;
    mode <= m;
    fault_at <= fa;
    fault_code <= fc;
    @(posedge clock);
    pclr <= 1'b0;
    exp_a.delete();
    exp_d.delete();
  endtask

  task automatic add_exp(logic [31:0] a, logic [4:0] r);
    exp_a.push_back(a);
    exp_d.push_back(regs[r]);
  endtask

  task automatic run_op(op_kind_e k, logic [4:0] rs, logic [4:0] rt,
      logic [2:0] rd, logic [11:0] off, logic [4:0] lst);
    int n;
    got_done = 1'b0;
    got_exc = 1'b0;
    got_wb = 1'b0;
    got_hold = 1'b0;
    @(posedge clock);
    op_valid <= 1'b1;
    op_kind <= k;
    op_rs <= rs;
    op_rt <= rt;
    op_rd <= rd;
    op_offset <= off;
    op_list <= lst;
    // Held until the edge after ready is seen high; that edge takes it.
    for (n = 0; n < 50 && op_ready !== 1'b1; n++)
      @(posedge clock);
    if (op_ready !== 1'b1)
    begin
      n_errors++;
      $display("mismatch at %0t: request never taken", $time);
      give_verdict();
    end
    @(posedge clock);
    op_valid <= 1'b0;
    for (n = 0; n < 300 && !got_done && !got_exc; n++)
    begin
      @(posedge clock);
      got_done = (op_done === 1'b1);
      got_exc = (exc_valid === 1'b1);
      if (irq_hold === 1'b1) got_hold = 1'b1;
      if (wb_valid === 1'b1)
      begin
        got_wb = 1'b1;
        wb_i = wb_idx;
        wb_d = wb_data;
      end
    end
    if (!got_done && !got_exc)
    begin
      n_errors++;
      $display("mismatch at %0t: operation never ended", $time);
      give_verdict();
    end
  endtask

  task automatic check_stores(string what);
    cmp_val(32'(pm.q_addr.size()), 32'(exp_a.size()), what);
    foreach (exp_a[i])
      if (i < pm.q_addr.size())
      begin
        cmp_val(pm.q_addr[i], exp_a[i], what);
        cmp_val(pm.q_data[i], exp_d[i], what);
      end
  endtask

  task automatic t_alu();
    regs[2] = 32'h0000_0004;
    regs[16] = 32'h0000_0008;
    run_op(short_modulo_subtract, 5'h02, 5'h00, 3'h1, 12'h000, 5'h00);
    cmp_flag(got_wb, 1'b1, "sub write-back");
    cmp_val({27'h0, wb_i}, 32'h11, "sub dest"); // dest map
    cmp_val(wb_d, 32'hFFFF_FFFC, "sub wrap"); // wrap result
    cmp_flag(got_exc, 1'b0, "sub trap"); // no trap
    for (int s = 0; s < 8; s++)
    begin
      run_op(short_exclusive_or, 5'(s), 5'(7 - s), 3'h0, 12'h0, 5'h0);
      cmp_val({27'h0, wb_i}, {27'h0, alu_reg(3'(7 - s))}, "xor dest");
      cmp_val(wb_d, regs[alu_reg(3'(s))] ^ regs[alu_reg(3'(7 - s))],
              "xor value"); // operands
    end
    $display("test alu done");
  endtask

  task automatic t_single();
    prep(2'h1, 8'hFF, 3'h0);
    for (int s = 0; s < 8; s++)
    begin
      run_op(short_word_store, 5'(s), 5'(7 - s), 3'h0, 12'(2 * s + 1), 5'h0);
      add_exp(regs[alu_reg(3'(s))] + 32'(8 * s + 4), dat_reg(3'(7 - s)));
      cmp_flag(got_hold, 1'b0, "single hold"); // single policy
    end
    run_op(stack_word_store, 5'h00, 5'h1F, 3'h0, 12'h01F, 5'h00);
    add_exp(regs[29] + 32'h7C, 5'h1F);
    check_stores("single stores"); // addr data
    $display("test single done");
  endtask

  task automatic t_misalign();
    regs[6] = 32'h0000_1002;
    regs[29] = 32'h0000_1002;
    for (int k = 2; k < 7; k++)
    begin
      prep(2'h0, 8'hFF, 3'h0);
      run_op(op_kind_e'(k), 5'h06, 5'h10, 3'h0, 12'h000, 5'h04);
      cmp_flag(got_exc, 1'b1, "misalign exc"); // address error
      cmp_val({29'h0, exc_code}, {29'h0, EXC_ADDR}, "misalign code");
      cmp_val(exc_addr, 32'h0000_1002, "misalign addr"); // address
      check_stores("misalign stores"); // nothing stored
    end
    regs[6] = 32'h5A06_0600;
    regs[29] = 32'h5A1D_1D00;
    $display("test misalign done");
  endtask

  task automatic t_wide();
    logic [4:0] lists [8] = '{5'h01, 5'h08, 5'h09, 5'h10, 5'h11, 5'h13,
                             5'h19, 5'h00};
    logic [31:0] a;
    int low;
    foreach (lists[i])
    begin
      prep(2'h2, 8'hFF, 3'h0);
      run_op(wide_multi_word_store, 5'h07, 5'h0, 3'h0, 12'hFF8, lists[i]);
      a = regs[7] - 32'h8;
      low = int'(lists[i][3:0]);
      for (int j = 0; j < ((low == 9) ? 8 : (low > 9) ? 0 : low); j++)
      begin
        add_exp(a, 5'(16 + j));
        a = a + 32'h4;
      end
      if (low == 9) add_exp(a, 5'h1E);
      if (low == 9) a = a + 32'h4;
      if (lists[i][4]) add_exp(a, 5'h1F);
      check_stores("wide list"); // order and addr
      cmp_flag(got_done, 1'b1, "wide done"); // completes
      if (exp_a.size() > 0) cmp_flag(got_hold, 1'b1, "wide hold");
    end
    $display("test wide done");
  endtask

  task automatic t_short_multi();
    for (int l = 0; l < 4; l++)
    begin
      prep(2'h1, 8'hFF, 3'h0);
      run_op(short_multi_word_store, 5'h0, 5'h0, 3'h0, 12'h003, 5'(l));
      for (int j = 0; j <= l; j++)
        add_exp(regs[29] + 32'(12 + 4 * j), 5'(16 + j));
      add_exp(regs[29] + 32'(16 + 4 * l), 5'h1F);
      check_stores("short list"); // list and start
    end
    $display("test short multi done");
  endtask

  task automatic t_pair();
    prep(2'h2, 8'hFF, 3'h0);
    // First register never 31, and never in a delay slot.
    run_op(paired_word_store, 5'h06, 5'h1E, 3'h0, 12'h7FC, 5'h0);
    add_exp(regs[6] + 32'h7FC, 5'h1E);
    add_exp(regs[6] + 32'h800, 5'h1F);
    run_op(paired_word_store, 5'h07, 5'h14, 3'h0, 12'h800, 5'h0);
    add_exp(regs[7] - 32'h800, 5'h14);
    add_exp(regs[7] - 32'h7FC, 5'h15);
    check_stores("pair"); // pair order
    cmp_flag(got_hold, 1'b1, "pair hold"); // held
    $display("test pair done");
  endtask

  task automatic t_fault();
    for (int c = 2; c < 6; c++)
    begin
      prep(2'h0, 8'h01, 3'(c));
      run_op(wide_multi_word_store, 5'h07, 5'h0, 3'h0, 12'h000, 5'h04);
      add_exp(regs[7], 5'h10);
      check_stores("fault stores"); // later words dropped
      cmp_flag(got_exc, 1'b1, "fault exc"); // fault reported
      cmp_flag(got_done, 1'b0, "fault done"); // no completion
      cmp_val({29'h0, exc_code}, 32'(c), "fault code"); // code
      cmp_val(exc_addr, regs[7] + 32'h4, "fault addr"); // word addr
    end
    $display("test fault done");
  endtask

  initial
  begin
    for (int i = 0; i < 32; i++)
      regs[i] = 32'h5A00_0000 + 32'(i) * 32'h0001_0100;
    regs[0] = 32'h0000_0000;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_alu();
    t_single();
    t_misalign();
    t_wide();
    t_short_multi();
    t_pair();
    t_fault();
    give_verdict();
  end
endmodule
